/* File: link_prog_pkg.sv */
// Shared constants for the debug-link flash programming registers
package link_prog_pkg;
  // Core clock and link idle timeout
  localparam int CORE_CLK_HZ = 10000000;
  localparam int IDLE_TIMEOUT_NS = 20000;
  localparam int IDLE_TIMEOUT_CYC = (IDLE_TIMEOUT_NS / 1000) *
                                    (CORE_CLK_HZ / 1000000);
  // Link register addresses
  localparam logic [7:0] ADDR_PROG_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_PROG_DATA = 8'hB4;
  // Reset values and the unmapped read value
  localparam logic [7:0] RST_PROG_CONTROL = 8'h00;
  localparam logic [7:0] RST_PROG_DATA = 8'h00;
  localparam logic [7:0] RST_REG_SELECT = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Unlock codes, written in this order
  localparam logic [7:0] UNLOCK_FIRST = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;
  // Flash command codes
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
  // Link instruction encodings (two bits after the start bit)
  localparam logic [1:0] INS_DATA_READ = 2'h0;
  localparam logic [1:0] INS_DATA_WRITE = 2'h1;
  localparam logic [1:0] INS_ADDR_READ = 2'h2;
  localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
  localparam int INS_BITS = 2;
  localparam int BYTE_BITS = 8;
endpackage

/* File: link_bus_if.sv */
// Byte-level carrier between the link shifter and the register block
`timescale 1ns/1ns
interface link_bus_if;
  logic wr_pulse;    // One-cycle write of wr_byte
  logic wr_is_addr;  // Write targets the register select
  logic [7:0] wr_byte;
  logic rd_pulse;    // One-cycle read request
  logic rd_is_addr;  // Read targets the register select
  logic [7:0] rd_byte; // Answer, valid in the rd_pulse cycle
  modport shifter (output wr_pulse, wr_is_addr, wr_byte, rd_pulse,
                   rd_is_addr, input rd_byte);
  modport regs (input wr_pulse, wr_is_addr, wr_byte, rd_pulse,
                rd_is_addr, output rd_byte);
endinterface

/* File: link_shifter.sv */
// Bit-level front end of the two-wire debug link
`timescale 1ns/1ns
module link_shifter #(
  parameter int TIMEOUT_CYC = link_prog_pkg::IDLE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw link pins
  input wire logic link_clk_pin,
  input wire logic link_data_in,
  output logic link_data_out,
  output logic link_data_oe,
  output logic busy,
  // Byte side
  link_bus_if.shifter bus
);
  // Elaboration check: the idle counter below is only 16 bits wide
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 65535) begin : g_bad_timeout
    $error("TIMEOUT_CYC out of range");
  end

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_INS = 2'b01,
    SH_WDATA = 2'b10,
    SH_RDATA = 2'b11
  } sh_state_t;

  logic [1:0] ck_sync_ff;   // Two-stage synchroniser, clock pin
  logic [1:0] dat_sync_ff;  // Two-stage synchroniser, data pin
  logic ck_prev_ff;         // Last synchronised clock level
  logic rise;
  logic fall;
  sh_state_t state_ff;
  logic [3:0] cnt_ff;       // Bits taken in the current phase
  logic [1:0] ins_ff;
  logic [7:0] sh_ff;        // Shift register, LSB first
  logic [15:0] idle_ff;     // Cycles since the last link edge
  logic out_ff;
  logic oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge finding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ck_sync_ff <= 2'h3;
      dat_sync_ff <= 2'h0;
      ck_prev_ff <= 1'b1;
    end else begin
      ck_sync_ff <= {ck_sync_ff[0], link_clk_pin};
      dat_sync_ff <= {dat_sync_ff[0], link_data_in};
      ck_prev_ff <= ck_sync_ff[1];
    end
  end

  assign rise = ck_sync_ff[1] & ~ck_prev_ff;
  assign fall = ~ck_sync_ff[1] & ck_prev_ff;

  ////////////////////////////////////////////////////////////////////////
  // Idle watchdog: a host that vanishes mid-frame cannot wedge the link
  always_ff @(posedge clk) begin
    if (!rst_n || rise || fall || state_ff == SH_IDLE) begin
      idle_ff <= 16'h0000;
    end else if (idle_ff != 16'(TIMEOUT_CYC)) begin
      idle_ff <= idle_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer: start bit, instruction, then eight data bits
  always_ff @(posedge clk) begin
    if (!rst_n || idle_ff == 16'(TIMEOUT_CYC)) begin
      state_ff <= SH_IDLE;
      cnt_ff <= 4'h0;
      ins_ff <= 2'h0;
      sh_ff <= 8'h00;
    end else if (state_ff == SH_RDATA && fall) begin
      sh_ff <= {1'b0, sh_ff[7:1]};
    end else if (rise) begin
      case (state_ff)
        SH_IDLE: begin
          // A high data bit on a rising edge starts a frame
          if (dat_sync_ff[1]) begin
            state_ff <= SH_INS;
          end
          cnt_ff <= 4'h0;
        end
        SH_INS: begin
          ins_ff <= {dat_sync_ff[1], ins_ff[1]};
          if (cnt_ff == 4'(link_prog_pkg::INS_BITS - 1)) begin
            cnt_ff <= 4'h0;
            // Bit 0, taken on the previous edge, tells write from read
            if (ins_ff[1] == 1'b1) begin
              state_ff <= SH_WDATA;
            end else begin
              // Load the answer before the first falling edge shifts it
              state_ff <= SH_RDATA;
              if (bus.rd_pulse) begin
                sh_ff <= bus.rd_byte;
              end
            end
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        SH_WDATA: begin
          sh_ff <= {dat_sync_ff[1], sh_ff[7:1]};
          if (cnt_ff == 4'(link_prog_pkg::BYTE_BITS - 1)) begin
            state_ff <= SH_IDLE;
          end
          cnt_ff <= cnt_ff + 4'h1;
        end
        SH_RDATA: begin
          // Host samples on this edge; stop after the eighth bit
          if (cnt_ff == 4'(link_prog_pkg::BYTE_BITS - 1)) begin
            state_ff <= SH_IDLE;
          end
          cnt_ff <= cnt_ff + 4'h1;
        end
        default: state_ff <= SH_IDLE;
      endcase
    end
  end

  // Read request on the edge that completes a read instruction; the
  // address/data bit is still on the pin then, not yet in ins_ff
  assign bus.rd_pulse = (state_ff == SH_INS) && rise && !ins_ff[1] &&
      cnt_ff == 4'(link_prog_pkg::INS_BITS - 1);
  assign bus.rd_is_addr = dat_sync_ff[1];
  assign bus.wr_pulse = (state_ff == SH_WDATA) && rise &&
                        cnt_ff == 4'(link_prog_pkg::BYTE_BITS - 1);
  // After the instruction, bit 1 (address or data) sits in ins_ff[1]
  assign bus.wr_is_addr = ins_ff[1];
  assign bus.wr_byte = {dat_sync_ff[1], sh_ff[7:1]};

  ////////////////////////////////////////////////////////////////////////
  // Data pin drive: new bit on each falling edge while reading
  always_ff @(posedge clk) begin
    if (!rst_n || state_ff != SH_RDATA) begin
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (fall) begin
      out_ff <= sh_ff[0];
      oe_ff <= 1'b1;
    end
  end

  assign link_data_out = out_ff;
  assign link_data_oe = oe_ff;
  assign busy = (state_ff != SH_IDLE);
endmodule

/* File: debug_link_flash_prog_regs.sv */
// Flash programming registers reached over the two-wire debug link
// Operation
// - 8-bit control register at 0x02, resets zero
// - Unlock needs 0x02 then 0x01, in order
// - Programming mode holds until system reset
// - 8-bit data register at 0xB4 carries bytes
// - Accept commands 06, 07, 08, 03
// - Halted device lends clock and data pins
// - Register select chooses data read/write target
`timescale 1ns/1ns
module debug_link_flash_prog_regs #(
  parameter int TIMEOUT_CYC = link_prog_pkg::IDLE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Debug link pins
  input wire logic LINK_CLK_PIN,
  input wire logic LINK_DATA_IN,
  output logic LINK_DATA_OUT,
  output logic LINK_DATA_OE,
  // Core control
  output logic CPU_HALT,
  output logic PINS_BORROWED,
  output logic PROG_ENABLED,
  // Flash engine side
  output logic [7:0] FLASH_CMD,
  output logic FLASH_CMD_VALID,
  output logic [7:0] FLASH_ARG,
  output logic FLASH_ARG_VALID,
  input wire logic FLASH_DONE,
  input wire logic [7:0] FLASH_RD_DATA,
  input wire logic FLASH_RD_VALID
);
  // Unlock tracker; a wrong code falls back to the start
  typedef enum logic [1:0] {
    LK_LOCKED = 2'b00,
    LK_GOT_FIRST = 2'b01,
    LK_UNLOCKED = 2'b10
  } lock_state_t;

  // Command tracker: one command byte, then its arguments
  typedef enum logic [0:0] {
    FC_WAIT_CMD = 1'b0,
    FC_ARGS = 1'b1
  } fcmd_state_t;

  // Byte carrier between the shifter and the registers
  link_bus_if bus ();

  logic link_busy;
  logic [7:0] reg_select_ff;   // Target of data read/write
  logic [7:0] prog_control_ff; // Last value written to control
  logic [7:0] prog_data_ff;    // Data register contents
  lock_state_t lock_ff;
  fcmd_state_t fcmd_ff;
  // Flash engine strobes are registered, one cycle each
  logic [7:0] cmd_ff;
  logic cmd_valid_ff;
  logic [7:0] arg_ff;
  logic arg_valid_ff;
  logic wr_ctl;
  logic wr_dat;

  // Valid flash command code check, used by the command FSM
  function automatic logic is_flash_cmd(input logic [7:0] c);
    is_flash_cmd = (c == link_prog_pkg::CMD_BLOCK_READ) ||
                   (c == link_prog_pkg::CMD_BLOCK_WRITE) ||
                   (c == link_prog_pkg::CMD_PAGE_ERASE) ||
                   (c == link_prog_pkg::CMD_DEVICE_ERASE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Link front end
  link_shifter #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_shifter (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .link_clk_pin(LINK_CLK_PIN),
    .link_data_in(LINK_DATA_IN),
    .link_data_out(LINK_DATA_OUT),
    .link_data_oe(LINK_DATA_OE),
    .busy(link_busy),
    .bus(bus.shifter)
  );

  // Data writes go where the register select points
  assign wr_ctl = bus.wr_pulse && !bus.wr_is_addr &&
      reg_select_ff == link_prog_pkg::ADDR_PROG_CONTROL;
  assign wr_dat = bus.wr_pulse && !bus.wr_is_addr &&
      reg_select_ff == link_prog_pkg::ADDR_PROG_DATA;

  ////////////////////////////////////////////////////////////////////////
  // Register select, written by address-write frames
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      reg_select_ff <= link_prog_pkg::RST_REG_SELECT;
    end else if (bus.wr_pulse && bus.wr_is_addr) begin
      reg_select_ff <= bus.wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped selections read as zero
  always_comb begin
    if (bus.rd_is_addr) begin
      bus.rd_byte = reg_select_ff;
    end else if (reg_select_ff == link_prog_pkg::ADDR_PROG_CONTROL) begin
      bus.rd_byte = prog_control_ff;
    end else if (reg_select_ff == link_prog_pkg::ADDR_PROG_DATA) begin
      bus.rd_byte = prog_data_ff;
    end else begin
      bus.rd_byte = link_prog_pkg::UNMAPPED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register storage
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      prog_control_ff <= link_prog_pkg::RST_PROG_CONTROL;
    end else if (wr_ctl) begin
      prog_control_ff <= bus.wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock sequence; only NRST leaves the unlocked state
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      lock_ff <= LK_LOCKED;
    end else if (wr_ctl) begin
      case (lock_ff)
        LK_LOCKED: begin
          if (bus.wr_byte == link_prog_pkg::UNLOCK_FIRST) begin
            lock_ff <= LK_GOT_FIRST;
          end
        end
        LK_GOT_FIRST: begin
          if (bus.wr_byte == link_prog_pkg::UNLOCK_SECOND) begin
            lock_ff <= LK_UNLOCKED;
          end else if (bus.wr_byte == link_prog_pkg::UNLOCK_FIRST) begin
            // A repeated first code may still begin a fresh pair
            lock_ff <= LK_GOT_FIRST;
          end else begin
            lock_ff <= LK_LOCKED;
          end
        end
        LK_UNLOCKED: lock_ff <= LK_UNLOCKED;
        default: lock_ff <= LK_LOCKED;
      endcase
    end else if (wr_dat && lock_ff == LK_GOT_FIRST) begin
      // A data register write between the pair restarts detection
      lock_ff <= LK_LOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data register: link writes, or read bytes from the flash engine
  // A link write wins over an engine byte landing in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      prog_data_ff <= link_prog_pkg::RST_PROG_DATA;
    end else if (wr_dat) begin
      prog_data_ff <= bus.wr_byte;
    end else if (FLASH_RD_VALID && lock_ff == LK_UNLOCKED) begin
      prog_data_ff <= FLASH_RD_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command phase: first byte is a command, then arguments until done
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      fcmd_ff <= FC_WAIT_CMD;
      cmd_ff <= 8'h00;
      cmd_valid_ff <= 1'b0;
      arg_ff <= 8'h00;
      arg_valid_ff <= 1'b0;
    end else begin
      // Strobes default low so each lasts exactly one cycle
      cmd_valid_ff <= 1'b0;
      arg_valid_ff <= 1'b0;
      case (fcmd_ff)
        FC_WAIT_CMD: begin
          // Locked or unknown codes are dropped without effect
          if (wr_dat && lock_ff == LK_UNLOCKED &&
              is_flash_cmd(bus.wr_byte)) begin
            cmd_ff <= bus.wr_byte;
            cmd_valid_ff <= 1'b1;
            fcmd_ff <= FC_ARGS;
          end
        end
        FC_ARGS: begin
          // Done wins over a late argument; the host must wait for it
          if (FLASH_DONE) begin
            fcmd_ff <= FC_WAIT_CMD;
          end else if (wr_dat) begin
            arg_ff <= bus.wr_byte;
            arg_valid_ff <= 1'b1;
          end
        end
        default: fcmd_ff <= FC_WAIT_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Halt and pin lending: core stalls while the link is in use
  // Trade-off: the core stays halted for the whole programming session,
  // which is safe but means user code cannot run until a reset
  assign PROG_ENABLED = (lock_ff == LK_UNLOCKED);
  assign CPU_HALT = PROG_ENABLED || link_busy;
  assign PINS_BORROWED = CPU_HALT;
  assign FLASH_CMD = cmd_ff;
  assign FLASH_CMD_VALID = cmd_valid_ff;
  assign FLASH_ARG = arg_ff;
  assign FLASH_ARG_VALID = arg_valid_ff;
endmodule

/* File: debug_link_flash_prog_regs_assertions.sv */
// Port-level checks for the flash programming register block
`timescale 1ns/1ns
module link_prog_checker #(
  parameter int TIMEOUT_CYC = link_prog_pkg::IDLE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Core control
  input wire logic CPU_HALT,
  input wire logic PINS_BORROWED,
  input wire logic PROG_ENABLED,
  // Flash engine side
  input wire logic [7:0] FLASH_CMD,
  input wire logic FLASH_CMD_VALID,
  input wire logic FLASH_ARG_VALID
);
  // One domain only, so one default clock
  default clocking cb @(posedge CORE_CLK); endclocking
  ////////////////////////////////////////////////////////////////////////
  // Reset has no disable: it is the cause under test
  reset_clears_a: assert property (!NRST |=> !PROG_ENABLED &&
    !FLASH_CMD_VALID && !FLASH_ARG_VALID && !CPU_HALT)
    else $error("outputs not cleared by reset");
  prog_sticky_a: assert property (disable iff (!NRST)
    PROG_ENABLED |=> PROG_ENABLED) else $error("programming mode dropped");
  halt_in_prog_a: assert property (disable iff (!NRST)
    PROG_ENABLED |-> CPU_HALT) else $error("core runs while unlocked");
  pins_follow_a: assert property (disable iff (!NRST)
    PINS_BORROWED == CPU_HALT) else $error("pins lent without halt");
  cmd_locked_a: assert property (disable iff (!NRST)
    FLASH_CMD_VALID |-> PROG_ENABLED) else $error("command while locked");
  cmd_code_a: assert property (disable iff (!NRST)
    FLASH_CMD_VALID |-> FLASH_CMD inside {8'h06, 8'h07, 8'h08, 8'h03})
    else $error("unknown command passed on");
  cmd_pulse_a: assert property (disable iff (!NRST)
    $rose(FLASH_CMD_VALID) |=> !FLASH_CMD_VALID)
    else $error("command strobe too long");
  arg_pulse_a: assert property (disable iff (!NRST)
    FLASH_ARG_VALID |=> !FLASH_ARG_VALID) else $error("arg strobe too long");
  cmd_arg_apart_a: assert property (disable iff (!NRST)
    !(FLASH_CMD_VALID && FLASH_ARG_VALID)) else $error("cmd and arg clash");
  // Main scenarios
  unlock_c: cover property ($rose(PROG_ENABLED));
  cmd_c: cover property (FLASH_CMD_VALID);
  arg_c: cover property (FLASH_ARG_VALID);
endmodule
bind debug_link_flash_prog_regs link_prog_checker #(
  .TIMEOUT_CYC(TIMEOUT_CYC)) chk (.CORE_CLK(CORE_CLK), .NRST(NRST),
  .CPU_HALT(CPU_HALT), .PINS_BORROWED(PINS_BORROWED),
  .PROG_ENABLED(PROG_ENABLED), .FLASH_CMD(FLASH_CMD),
  .FLASH_CMD_VALID(FLASH_CMD_VALID), .FLASH_ARG_VALID(FLASH_ARG_VALID));

/* File: link_host.sv */
// Behavioural programming host driving the two link pins
`timescale 1ns/1ns
module link_host (
  // Core clock paces the link
  input wire logic clk,
  // Data line as the host sees it, pull-up included
  input wire logic dev_data,
  // Link pins toward the device
  output logic link_clk,
  output logic link_data
);
  // Clock idles high and stands still between frames
  initial begin
    link_clk = 1'b1; // Only the host drives this pin
    link_data = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Start bit, two instruction bits, a byte; all LSB first, 800 ns bits
  task automatic frame(input logic [1:0] ins, input logic [7:0] v);
    logic [10:0] bits;
    bits = {v, ins, 1'b1};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      link_clk <= 1'b0;
      link_data <= bits[i]; // Held through the high half
      repeat (4) @(posedge clk);
      link_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    // Released line must not keep showing the last bit
    link_data <= ~link_data;
    repeat (20) @(posedge clk);
  endtask
  // Read frame: start bit and instruction, then eight clock pulses with
  // the device's bit taken on each rising edge, LSB first
  task automatic read_frame(input logic [1:0] ins, output logic [7:0] v);
    logic [2:0] hdr;
    hdr = {ins, 1'b1};
    v = 8'h00;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      link_clk <= 1'b0;
      if (i < 3) begin
        link_data <= hdr[i];
      end
      repeat (4) @(posedge clk);
      if (i >= 3) begin
        v[i - 3] = dev_data;
      end
      link_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    repeat (24) @(posedge clk);
  endtask
endmodule

/* File: debug_link_flash_prog_regs_test.sv */
// Self-checking bench for the flash programming register block
`timescale 1ns/1ns
module debug_link_flash_prog_regs_test;
  // Bench signals
  logic core_clk, nrst, lclk, ldat, cpu_halt, pins_borrowed, prog_enabled;
  logic flash_cmd_valid, flash_arg_valid, flash_done, flash_rd_valid;
  logic [7:0] flash_cmd, flash_arg, flash_rd_data, last_cmd, last_arg, v;
  logic [7:0] rv, exp_rd;
  logic dout, doe, dline;
  int n_errors = 0;
  int checks_done = 0;
  int n_cmd = 0;
  int n_arg = 0;
  int seed = 32'hE5ED;
  logic [7:0] codes [4] = '{link_prog_pkg::CMD_BLOCK_READ,
    link_prog_pkg::CMD_BLOCK_WRITE, link_prog_pkg::CMD_PAGE_ERASE,
    link_prog_pkg::CMD_DEVICE_ERASE};
  // Pull-up holds the data line high whenever the device lets it go
  assign dline = doe ? dout : 1'b1;
  link_host host (.clk(core_clk), .dev_data(dline), .link_clk(lclk),
    .link_data(ldat));
  debug_link_flash_prog_regs dut (.CORE_CLK(core_clk), .NRST(nrst),
    .LINK_CLK_PIN(lclk), .LINK_DATA_IN(ldat), .LINK_DATA_OUT(dout),
    .LINK_DATA_OE(doe), .CPU_HALT(cpu_halt), .PINS_BORROWED(pins_borrowed),
    .PROG_ENABLED(prog_enabled), .FLASH_CMD(flash_cmd),
    .FLASH_CMD_VALID(flash_cmd_valid), .FLASH_ARG(flash_arg),
    .FLASH_ARG_VALID(flash_arg_valid), .FLASH_DONE(flash_done),
    .FLASH_RD_DATA(flash_rd_data), .FLASH_RD_VALID(flash_rd_valid));
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Random byte that is never a command nor an unlock code
  function automatic logic [7:0] non_cmd();
    return 8'($random(seed)) | 8'h80;
  endfunction
  // Link register select, then data write
  task automatic sel(input logic [7:0] a);
    host.frame(link_prog_pkg::INS_ADDR_WRITE, a);
  endtask
  task automatic put(input logic [7:0] d);
    host.frame(link_prog_pkg::INS_DATA_WRITE, d);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Strobes are one cycle wide, so count them as they pass
  always @(posedge core_clk) begin
    if (flash_cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = flash_cmd;
    end
    if (flash_arg_valid === 1'b1) begin
      n_arg++;
      last_arg = flash_arg;
    end
  end
  // 100 ns core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Cut a hang short well past the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    flash_done = 1'b0;
    flash_rd_valid = 1'b0;
    flash_rd_data = 8'h00;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(8'(prog_enabled), 8'h00);
    // Command while locked is stored but not passed on
    sel(link_prog_pkg::ADDR_PROG_DATA);
    put(link_prog_pkg::CMD_BLOCK_WRITE);
    check(8'(n_cmd), 8'h00);
    check(8'(cpu_halt), 8'h00);
    // Wrong order, then a stray value between the pair
    sel(link_prog_pkg::ADDR_PROG_CONTROL);
    put(link_prog_pkg::UNLOCK_SECOND);
    put(link_prog_pkg::UNLOCK_FIRST);
    put(non_cmd());
    put(link_prog_pkg::UNLOCK_SECOND);
    check(8'(prog_enabled), 8'h00);
    put(link_prog_pkg::UNLOCK_FIRST);
    put(link_prog_pkg::UNLOCK_SECOND);
    check(8'(prog_enabled), 8'h01);
    check(8'(pins_borrowed), 8'h01);
    // Control reads back the last code; the select reads back its address
    host.read_frame(link_prog_pkg::INS_DATA_READ, rv);
    check(rv, link_prog_pkg::UNLOCK_SECOND);
    host.read_frame(link_prog_pkg::INS_ADDR_READ, rv);
    check(rv, link_prog_pkg::ADDR_PROG_CONTROL);
    // A byte from the flash engine comes back through the data register
    @(posedge core_clk);
    exp_rd = 8'($random(seed));
    flash_rd_data <= exp_rd;
    flash_rd_valid <= 1'b1;
    @(posedge core_clk);
    flash_rd_valid <= 1'b0;
    sel(link_prog_pkg::ADDR_PROG_DATA);
    host.read_frame(link_prog_pkg::INS_DATA_READ, rv);
    check(rv, exp_rd);
    // Every command, each with one random argument byte
    for (int i = 0; i < 4; i++) begin
      put(codes[i]);
      check(8'(n_cmd), 8'(i + 1));
      check(last_cmd, codes[i]);
      v = 8'($random(seed));
      put(v);
      check(8'(n_arg), 8'(i + 1));
      check(last_arg, v);
      @(posedge core_clk);
      flash_done <= 1'b1;
      @(posedge core_clk);
      flash_done <= 1'b0;
    end
    put(non_cmd());
    check(8'(n_cmd), 8'h04);
    // Mode stays until a system reset ends it
    repeat (300) @(posedge core_clk);
    check(8'(prog_enabled), 8'h01);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(8'(prog_enabled), 8'h00);
    check(8'(cpu_halt), 8'h00);
    // Control register is back at its reset value
    sel(link_prog_pkg::ADDR_PROG_CONTROL);
    host.read_frame(link_prog_pkg::INS_DATA_READ, rv);
    check(rv, link_prog_pkg::RST_PROG_CONTROL);
    wrap_up();
  end
endmodule
